//--- sgo_servo_gain_observer_select.sv
// Top of the servo gain and observer selection block.
// Assumes MCLK at 20 MHz, all inputs synchronous to it, and a register
// master that keeps to one-cycle strobes and takes read data one cycle later.
//
// Overview of operation
// - The disturbance observer works only when its enable bit in the function word is one.
// - A second function bit makes the observer work always or only while first gain is in use.
// - The observer works only in position or velocity control mode.
// - The observer needs servo-on, auto-tuning off and the speed observer bit cleared.
// - The filtered disturbance estimate is scaled by the compensating gain before the torque sum.
// - The estimate is low-pass filtered with a programmable time, shorter meaning less delay.
// - Third gain is only used in position or full-closed mode with servo-on.
// - Each third gain is the first gain times the scale factor divided by one hundred.
// - The third gain is held for the programmed valid time.
// - Only position and speed gains take third values; other terms keep first values.
// - A second gain condition during the third gain period returns to second gain.
// - The position gain step from second to third gain is ramped over the position gain switching time.
// - A second-to-first change caused by a parameter write still passes through third gain.
// - In switching mode seven the second condition is a present positional command.
`default_nettype none
module sgo_servo_gain_observer_select
  import sgo_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 RESETN,
  // Register port
  input  wire logic [ADDR_W-1:0]    REG_ADDR,
  input  wire logic [DATA_W-1:0]    REG_WDATA,
  input  wire logic                 REG_WE,
  input  wire logic                 REG_RE,
  output logic [DATA_W-1:0]         REG_RDATA,
  // Drive state
  input  wire logic                 SERVO_ON,
  input  wire logic                 SECOND_GAIN_COND,
  input  wire logic                 POS_CMD_ACTIVE,
  // Gain sets
  input  wire sgo_gain_set_t        FIRST_GAINS,
  input  wire sgo_gain_set_t        SECOND_GAINS,
  output sgo_gain_set_t             GAIN_OUT,
  output sgo_gain_state_t           GAIN_STATE,
  // Torque path
  input  wire logic signed [15:0]   DIST_EST,
  input  wire logic signed [15:0]   TORQUE_CMD_IN,
  output logic signed [15:0]        DIST_COMP,
  output logic signed [15:0]        TORQUE_CMD_OUT,
  output logic                      OBS_ACTIVE
);
  if (TICK_DIV < 2) begin : g_bad_div
    $error("sgo_servo_gain_observer_select: TICK_DIV must be at least 2");
  end

  localparam int DIV_W = $clog2(TICK_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  function automatic logic [15:0] sat_u16(input logic [31:0] v);
    return (v > U16_MAX) ? 16'hFFFF : v[15:0];
  endfunction

  function automatic logic signed [15:0] sat_s16(input logic signed [33:0] v);
    logic signed [15:0] r;
    r = v[15:0];
    if (v > S16_MAX) r = 16'sh7FFF;
    else if (v < S16_MIN) r = 16'sh8000;
    return r;
  endfunction

  logic [DATA_W-1:0]  cfg_reg [NUM_CFG];
  logic [DIV_W-1:0]   div_reg;
  logic               tick_reg;
  sgo_gain_state_t    state_reg;
  sgo_gain_state_t    state_next;
  logic [15:0]        remain_reg;
  logic [15:0]        remain_next;
  logic [DATA_W-1:0]  rd_mux;
  logic [31:0]        third_pos_prod;
  logic [31:0]        third_spd_prod;
  logic signed [33:0] comp_prod;
  logic signed [33:0] torque_sum;
  logic signed [16:0] ramp_x;
  logic signed [16:0] ramp_y;
  logic signed [15:0] dist_filt;
  sgo_gain_set_t      gain_next;

  // Configuration fields
  wire [15:0] func_word    = cfg_reg[REG_FUNC_EXP];
  wire [15:0] comp_gain    = cfg_reg[REG_COMP_GAIN];
  wire [15:0] filter_time  = cfg_reg[REG_FILTER_TIME];
  wire [15:0] valid_time   = cfg_reg[REG_VALID_TIME];
  wire [15:0] scale_factor = cfg_reg[REG_SCALE];
  wire [15:0] switch_time  = cfg_reg[REG_SWITCH_TIME];
  wire [15:0] switch_mode  = cfg_reg[REG_SWITCH_MODE];
  wire [15:0] control_mode = cfg_reg[REG_CONTROL_MODE];
  wire [15:0] autotune     = cfg_reg[REG_AUTOTUNE];

  // Register decode
  wire cfg_hit = REG_ADDR < ADDR_W'(NUM_CFG);
  wire cfg_we  = REG_WE && cfg_hit;

  // Control-cycle divider
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      div_reg  <= DIV_ZERO;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= (div_reg == DIV_LAST) ? DIV_ZERO : div_reg + DIV_W'(1);
      tick_reg <= (div_reg == DIV_LAST);
    end
  end

  // Writes go straight into the setting words; a mode write can end second gain
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_reg[i] <= (i == int'(REG_SCALE)) ? SCALE_RESET : CFG_RESET;
      end
    end else if (cfg_we) begin
      cfg_reg[REG_ADDR] <= REG_WDATA;
    end
  end

  // Second gain condition and third gain qualification
  wire cond2 = (switch_mode == PSM_POS_CMD) ? POS_CMD_ACTIVE : SECOND_GAIN_COND;
  wire third_ok = SERVO_ON && (control_mode == CM_POSITION ||
                               control_mode == CM_FULL_CLOSED);
  wire timer_zero = remain_reg == ZERO16;

  always_comb begin
    state_next  = state_reg;
    remain_next = remain_reg;
    unique case (state_reg)
      GS_FIRST: begin
        if (cond2) state_next = GS_SECOND;
      end
      GS_SECOND: begin
        // A fall of the condition, a parameter write included, enters third gain when third_ok holds and valid time is nonzero
        if (!cond2) begin
          if (third_ok && valid_time != ZERO16) begin
            state_next  = GS_THIRD;
            remain_next = valid_time;
          end else begin
            state_next = GS_FIRST;
          end
        end
      end
      GS_THIRD: begin
        if (cond2) begin
          state_next  = GS_SECOND;
          remain_next = ZERO16;
        end else if (!third_ok || timer_zero) begin
          state_next  = GS_FIRST;
          remain_next = ZERO16;
        end else if (tick_reg) begin
          remain_next = remain_reg - ONE16;
        end
      end
      default: begin
        state_next  = GS_FIRST;
        remain_next = ZERO16;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg  <= GS_FIRST;
      remain_reg <= ZERO16;
    end else begin
      state_reg  <= state_next;
      remain_reg <= remain_next;
    end
  end

  // Third gain values
  assign third_pos_prod = 32'(FIRST_GAINS.pos_gain) * 32'(scale_factor);
  assign third_spd_prod = 32'(FIRST_GAINS.speed_gain) * 32'(scale_factor);
  wire [15:0] third_pos = sat_u16(third_pos_prod / PERCENT_U);
  wire [15:0] third_spd = sat_u16(third_spd_prod / PERCENT_U);

  wire in_second = state_reg == GS_SECOND;
  wire in_third  = state_reg == GS_THIRD;
  wire [15:0] pos_target = in_second ? SECOND_GAINS.pos_gain :
                           in_third ? third_pos : FIRST_GAINS.pos_gain;

  // Ramp only on the second-to-third step; other changes are immediate
  assign ramp_x = $signed({1'b0, pos_target});
  wire ramp_bypass = !in_third || switch_time == ZERO16;

  sgo_lowpass #(
    .W     (17),
    .SHIFT (LP_SHIFT)
  ) u_gain_ramp (
    .clk    (MCLK),
    .rst_n  (RESETN),
    .tick   (tick_reg),
    .bypass (ramp_bypass),
    .period (switch_time),
    .x      (ramp_x),
    .y      (ramp_y)
  );

  always_comb begin
    gain_next               = FIRST_GAINS;
    gain_next.pos_gain      = ramp_y[15:0];
    if (in_second) gain_next = SECOND_GAINS;
    if (in_second) gain_next.pos_gain = ramp_y[15:0];
    if (in_third) gain_next.speed_gain = third_spd;
  end

  // Observer qualification
  wire mode_obs = control_mode == CM_POSITION || control_mode == CM_VELOCITY;
  wire cond_obs = SERVO_ON && autotune == ZERO16 && !func_word[FE_SPEED_OBS_BIT];
  wire gain_obs = !func_word[FE_DIST_MODE_BIT] || state_reg == GS_FIRST;
  wire obs_on   = func_word[FE_DIST_OBS_BIT] && mode_obs && cond_obs && gain_obs;

  sgo_lowpass #(
    .W     (16),
    .SHIFT (LP_SHIFT)
  ) u_dist_filter (
    .clk    (MCLK),
    .rst_n  (RESETN),
    .tick   (tick_reg),
    .bypass (filter_time == ZERO16),
    .period (filter_time),
    .x      (DIST_EST),
    .y      (dist_filt)
  );

  // Compensating gain is in percent of the filtered estimate
  assign comp_prod = 34'(dist_filt) * $signed({18'h00000, comp_gain});
  wire signed [15:0] comp_val  = obs_on ? sat_s16(comp_prod / PERCENT_S) : 16'sh0000;
  assign torque_sum = 34'(TORQUE_CMD_IN) + 34'(comp_val);

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      GAIN_OUT       <= '0;
      GAIN_STATE     <= GS_FIRST;
      DIST_COMP      <= 16'sh0000;
      TORQUE_CMD_OUT <= 16'sh0000;
      OBS_ACTIVE     <= 1'b0;
    end else begin
      GAIN_OUT       <= gain_next;
      GAIN_STATE     <= state_reg;
      DIST_COMP      <= comp_val;
      TORQUE_CMD_OUT <= sat_s16(torque_sum);
      OBS_ACTIVE     <= obs_on;
    end
  end

  // Read path; data stand only in the cycle after the strobe
  always_comb begin
    rd_mux = ZERO16;
    if (cfg_hit) begin
      rd_mux = cfg_reg[REG_ADDR];
    end else if (REG_ADDR == REG_STATUS) begin
      rd_mux[ST_OBS_BIT]                 = OBS_ACTIVE;
      rd_mux[ST_STATE_LSB +: 3]          = state_reg;
    end else if (REG_ADDR == REG_REMAIN) begin
      rd_mux = remain_reg;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= ZERO16;
    end else begin
      REG_RDATA <= REG_RE ? rd_mux : ZERO16;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  sequence s_leave_second;
    state_reg == GS_SECOND && !cond2 && third_ok && valid_time != ZERO16;
  endsequence

  sequence s_third_loaded;
    state_reg == GS_THIRD && remain_reg == $past(valid_time);
  endsequence

  chk_obs_enable_bit : assert property (
    !func_word[FE_DIST_OBS_BIT] |=> !OBS_ACTIVE && DIST_COMP == 16'sh0000)
    else $error("observer active with enable bit clear");
  chk_obs_first_only : assert property (
    (func_word[FE_DIST_MODE_BIT] && state_reg != GS_FIRST) |=> !OBS_ACTIVE)
    else $error("observer active outside first gain in first-only mode");
  chk_obs_ctrl_mode : assert property (
    (control_mode != CM_POSITION && control_mode != CM_VELOCITY) |=> !OBS_ACTIVE)
    else $error("observer active in unsupported control mode");
  chk_obs_conditions : assert property (
    (!SERVO_ON || autotune != ZERO16 || func_word[FE_SPEED_OBS_BIT]) |=> !OBS_ACTIVE)
    else $error("observer active without its operating conditions");
  chk_comp_torque_sum : assert property (
    !obs_on |=> TORQUE_CMD_OUT == $past(TORQUE_CMD_IN))
    else $error("torque changed while observer inactive");
  chk_third_mode_gate : assert property (
    (state_reg == GS_THIRD && !third_ok && !cond2) |=> state_reg == GS_FIRST)
    else $error("third gain kept outside its modes");
  chk_third_scale_value : assert property (
    (state_reg == GS_THIRD) |=> GAIN_OUT.speed_gain == $past(third_spd))
    else $error("third speed gain not first gain times scale");
  chk_third_timer_load : assert property (
    s_leave_second |=> s_third_loaded)
    else $error("third period not loaded with valid time");
  chk_keep_first_terms : assert property (
    (state_reg != GS_SECOND) |=> GAIN_OUT.vi_time == $past(FIRST_GAINS.vi_time) &&
      GAIN_OUT.torque_filter == $past(FIRST_GAINS.torque_filter))
    else $error("non-scaled terms left first gain values");
  chk_second_wins : assert property (
    (state_reg == GS_THIRD && cond2) |=> state_reg == GS_SECOND)
    else $error("second gain condition ignored in third period");
  chk_mode7_command : assert property (
    (state_reg == GS_FIRST && switch_mode == PSM_POS_CMD && POS_CMD_ACTIVE) |=>
      state_reg == GS_SECOND)
    else $error("positional command did not select second gain");
  chk_third_expiry : assert property (
    (state_reg == GS_THIRD && timer_zero && !cond2) |=> state_reg == GS_FIRST)
    else $error("first gain not resumed at third period expiry");
endmodule // sgo_servo_gain_observer_select
`default_nettype wire

//--- sgo_pkg.sv
// Package for the servo gain and observer selection block: register map,
// field positions, mode codes, timing constants and shared types.
// Assumes a single 20 MHz control clock.
`default_nettype none
package sgo_pkg;
  // Bus widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_PERIOD_NS = 100000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Register indices
  localparam logic [ADDR_W-1:0] REG_FUNC_EXP     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_COMP_GAIN    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FILTER_TIME  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_VALID_TIME   = 4'h3;
  localparam logic [ADDR_W-1:0] REG_SCALE        = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SWITCH_TIME  = 4'h5;
  localparam logic [ADDR_W-1:0] REG_SWITCH_MODE  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_CONTROL_MODE = 4'h7;
  localparam logic [ADDR_W-1:0] REG_AUTOTUNE     = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATUS       = 4'h9;
  localparam logic [ADDR_W-1:0] REG_REMAIN       = 4'hA;
  localparam int                NUM_CFG          = 9;

  // Reset values
  localparam logic [DATA_W-1:0] CFG_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] SCALE_RESET = 16'h0064;
  localparam logic [DATA_W-1:0] ZERO16      = 16'h0000;
  localparam logic [DATA_W-1:0] ONE16       = 16'h0001;

  // Function expansion word fields
  localparam int FE_SPEED_OBS_BIT = 0;
  localparam int FE_DIST_OBS_BIT  = 1;
  localparam int FE_DIST_MODE_BIT = 2;

  // Status fields
  localparam int ST_OBS_BIT   = 0;
  localparam int ST_STATE_LSB = 1;

  // Mode codes
  localparam logic [DATA_W-1:0] CM_POSITION    = 16'h0000;
  localparam logic [DATA_W-1:0] CM_VELOCITY    = 16'h0001;
  localparam logic [DATA_W-1:0] CM_FULL_CLOSED = 16'h0006;
  localparam logic [DATA_W-1:0] PSM_POS_CMD    = 16'h0007;

  // Arithmetic constants
  localparam logic        [31:0] PERCENT_U = 32'h00000064;
  localparam logic signed [33:0] PERCENT_S = 34'sh000000064;
  localparam logic        [31:0] U16_MAX   = 32'h0000FFFF;
  localparam logic signed [33:0] S16_MAX   = 34'sh000007FFF;
  localparam logic signed [33:0] S16_MIN   = 34'sh3FFFF8000;

  // Low-pass step is one eighth of the error per update
  localparam int LP_SHIFT = 3;

  typedef enum logic [2:0] {
    GS_FIRST  = 3'b001,
    GS_SECOND = 3'b010,
    GS_THIRD  = 3'b100
  } sgo_gain_state_t;

  typedef struct packed {
    logic [15:0] pos_gain;
    logic [15:0] speed_gain;
    logic [15:0] vi_time;
    logic [15:0] speed_filter;
    logic [15:0] torque_filter;
  } sgo_gain_set_t;
endpackage
`default_nettype wire

//--- sgo_lowpass.sv
// First-order low-pass stage updated every PERIOD control ticks.
// Assumes tick is a one-cycle enable from the control-cycle divider.
`default_nettype none
module sgo_lowpass
  import sgo_pkg::*;
#(
  parameter int W     = 16,
  parameter int SHIFT = LP_SHIFT
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Control
  input  wire logic                tick,
  input  wire logic                bypass,
  input  wire logic [15:0]         period,
  // Data
  input  wire logic signed [W-1:0] x,
  output logic signed [W-1:0]      y
);
  if (W < 2 || SHIFT < 1 || SHIFT >= W) begin : g_bad_param
    $error("sgo_lowpass: unsupported width or shift");
  end

  logic        [15:0] cnt_reg;
  logic signed [W:0]  diff;
  logic signed [W:0]  step_raw;
  logic signed [W:0]  step;
  logic signed [W:0]  y_sum;
  wire                due;

  // A larger period slows the update: longer delay, less noise
  assign diff     = {x[W-1], x} - {y[W-1], y};
  assign step_raw = diff >>> SHIFT;
  // Without a minimum step the output would stall short of the input
  assign step     = (step_raw == '0 && diff != '0) ? (diff[W] ? '1 : (W+1)'(1)) : step_raw;
  assign y_sum    = {y[W-1], y} + step;
  assign due      = tick && (cnt_reg >= period - ONE16);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= ZERO16;
    end else if (bypass || due) begin
      cnt_reg <= ZERO16;
    end else if (tick) begin
      cnt_reg <= cnt_reg + ONE16;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      y <= '0;
    end else if (bypass) begin
      y <= x;
    end else if (due) begin
      y <= y_sum[W-1:0];
    end
  end

  chk_filter_hold : assert property (@(posedge clk) disable iff (!rst_n)
    (!bypass && !tick) |=> $stable(y))
    else $error("filter output moved without an update tick");
endmodule // sgo_lowpass
`default_nettype wire

//--- test_servo_gain_observer_select.sv
// Self-checking bench for the servo gain and observer selection block.
// Assumes the block's package is compiled first; drives every port itself.
`default_nettype none
module test_servo_gain_observer_select
  import sgo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Short tick keeps third-gain and filter times to a few hundred cycles
  localparam int TD = 10;
  localparam sgo_gain_set_t FG = '{16'h0064, 16'h0032, 16'h0001, 16'h0002, 16'h0003};
  localparam sgo_gain_set_t SG = '{16'h000A, 16'h000A, 16'h000A, 16'h000A, 16'h000A};
  localparam sgo_gain_set_t TG = '{16'h00C8, 16'h0064, 16'h0001, 16'h0002, 16'h0003};
  logic              mclk, resetn, reg_we, reg_re, servo_on, cond2, pos_cmd, obs_active;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  sgo_gain_set_t     gain_out;
  sgo_gain_state_t   gain_state;
  logic signed [15:0] dist_est, torque_in, dist_comp, torque_out;
  int                fail_count, total_checks, cyc, n;

  sgo_servo_gain_observer_select #(.TICK_DIV(TD)) i_sgo_servo_gain_observer_select (
    .MCLK(mclk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .SERVO_ON(servo_on),
    .SECOND_GAIN_COND(cond2), .POS_CMD_ACTIVE(pos_cmd), .FIRST_GAINS(FG),
    .SECOND_GAINS(SG), .GAIN_OUT(gain_out), .GAIN_STATE(gain_state),
    .DIST_EST(dist_est), .TORQUE_CMD_IN(torque_in), .DIST_COMP(dist_comp),
    .TORQUE_CMD_OUT(torque_out), .OBS_ACTIVE(obs_active)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits, then steps past the edge so registered outputs have settled
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic set_lvl(input logic so, input logic c2, input logic pc);
    @(posedge mclk);
    servo_on <= so;
    cond2 <= c2;
    pos_cmd <= pc;
  endtask

  task automatic test_regs();
    logic [DATA_W-1:0] d;
    rd(REG_SCALE, d);
    chk({64'h0, d}, {64'h0, 16'h0064});
    rd(REG_STATUS, d);
    chk({64'h0, d}, {64'h0, 16'h0002});
    wr(REG_STATUS, 16'hFFFF);
    rd(REG_STATUS, d);
    chk({64'h0, d}, {64'h0, 16'h0002});
    rd(4'hB, d);
    chk({64'h0, d}, {64'h0, 16'h0000});
    $display("test_regs done");
  endtask

  task automatic obs_case(input logic [15:0] fw, input logic [15:0] cm, input logic [15:0] at,
                          input logic so, input logic c2, input logic exp);
    wr(REG_FUNC_EXP, fw);
    wr(REG_CONTROL_MODE, cm);
    wr(REG_AUTOTUNE, at);
    set_lvl(so, c2, 1'b0);
    wait_cyc(8);
    chk({79'h0, obs_active}, {79'h0, exp});
    chk({64'h0, dist_comp}, {64'h0, exp ? 16'h0064 : 16'h0000});
  endtask

  task automatic test_observer();
    wr(REG_COMP_GAIN, 16'h0064);
    obs_case(16'h0002, CM_POSITION, 16'h0000, 1'b1, 1'b0, 1'b1);
    obs_case(16'h0000, CM_POSITION, 16'h0000, 1'b1, 1'b0, 1'b0);
    obs_case(16'h0003, CM_POSITION, 16'h0000, 1'b1, 1'b0, 1'b0);
    obs_case(16'h0002, CM_VELOCITY, 16'h0000, 1'b1, 1'b0, 1'b1);
    obs_case(16'h0002, 16'h0002, 16'h0000, 1'b1, 1'b0, 1'b0);
    obs_case(16'h0002, CM_POSITION, 16'h0001, 1'b1, 1'b0, 1'b0);
    obs_case(16'h0002, CM_POSITION, 16'h0000, 1'b0, 1'b0, 1'b0);
    obs_case(16'h0006, CM_POSITION, 16'h0000, 1'b1, 1'b0, 1'b1);
    obs_case(16'h0006, CM_POSITION, 16'h0000, 1'b1, 1'b1, 1'b0);
    obs_case(16'h0002, CM_POSITION, 16'h0000, 1'b1, 1'b1, 1'b1);
    chk({64'h0, torque_out}, {64'h0, 16'h044C});
    set_lvl(1'b1, 1'b0, 1'b0);
    wr(REG_COMP_GAIN, 16'h0032);
    @(posedge mclk);
    dist_est <= -16'sd51;
    torque_in <= 16'sh7FF0;
    wait_cyc(8);
    chk({64'h0, dist_comp}, {64'h0, 16'hFFE7});
    @(posedge mclk);
    dist_est <= 16'sd100;
    wait_cyc(8);
    chk({64'h0, torque_out}, {64'h0, 16'h7FFF});
    $display("test_observer done");
  endtask

  task automatic test_filter();
    wr(REG_COMP_GAIN, 16'h0064);
    @(posedge mclk);
    dist_est <= 16'sd0;
    wait_cyc(6);
    wr(REG_FILTER_TIME, 16'h0001);
    @(posedge mclk);
    dist_est <= 16'sd80;
    wait_cyc(4);
    chk({79'h0, dist_comp != 16'sd80}, 80'h1);
    wait_cyc(700);
    chk({64'h0, dist_comp}, {64'h0, 16'h0050});
    wr(REG_FILTER_TIME, 16'h0000);
    $display("test_filter done");
  endtask

  // One second-gain episode; the state after the condition falls is judged
  task automatic gcycle(input logic [15:0] cm, input logic so, input sgo_gain_state_t exp);
    wr(REG_CONTROL_MODE, cm);
    set_lvl(so, 1'b1, 1'b0);
    wait_cyc(5);
    set_lvl(so, 1'b0, 1'b0);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, exp});
    wait_cyc(60);
  endtask

  task automatic test_third();
    wr(REG_FUNC_EXP, 16'h0000);
    wr(REG_VALID_TIME, 16'h0003);
    wr(REG_SCALE, 16'h00C8);
    wr(REG_CONTROL_MODE, CM_POSITION);
    set_lvl(1'b1, 1'b1, 1'b0);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, GS_SECOND});
    chk(gain_out, SG);
    set_lvl(1'b1, 1'b0, 1'b0);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, GS_THIRD});
    chk(gain_out, TG);
    n = 0;
    while (gain_state !== GS_FIRST && n < 100) begin
      wait_cyc(1);
      n++;
    end
    chk({79'h0, n >= 12 && n <= 35}, 80'h1);
    // Position gain passes one extra flop in the ramp stage
    wait_cyc(1);
    chk(gain_out, FG);
    set_lvl(1'b1, 1'b1, 1'b0);
    wait_cyc(5);
    set_lvl(1'b1, 1'b0, 1'b0);
    wait_cyc(5);
    set_lvl(1'b1, 1'b1, 1'b0);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, GS_SECOND});
    chk(gain_out, SG);
    set_lvl(1'b1, 1'b0, 1'b0);
    // Leaving position mode inside the period must end it at once
    wr(REG_CONTROL_MODE, CM_VELOCITY);
    wait_cyc(3);
    chk({77'h0, gain_state}, {77'h0, GS_FIRST});
    wait_cyc(60);
    gcycle(CM_FULL_CLOSED, 1'b1, GS_THIRD);
    gcycle(CM_VELOCITY, 1'b1, GS_FIRST);
    gcycle(CM_POSITION, 1'b0, GS_FIRST);
    wr(REG_VALID_TIME, 16'h0000);
    gcycle(CM_POSITION, 1'b1, GS_FIRST);
    $display("test_third done");
  endtask

  task automatic test_cmd_mode();
    wr(REG_VALID_TIME, 16'h0003);
    wr(REG_SWITCH_MODE, PSM_POS_CMD);
    set_lvl(1'b1, 1'b1, 1'b0);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, GS_FIRST});
    set_lvl(1'b1, 1'b1, 1'b1);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, GS_SECOND});
    set_lvl(1'b1, 1'b1, 1'b0);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, GS_THIRD});
    wait_cyc(60);
    // Condition held high, so leaving mode 7 selects second gain at once
    wr(REG_SWITCH_MODE, 16'h0000);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, GS_SECOND});
    wr(REG_SWITCH_MODE, PSM_POS_CMD);
    wait_cyc(5);
    chk({77'h0, gain_state}, {77'h0, GS_THIRD});
    set_lvl(1'b1, 1'b0, 1'b0);
    wait_cyc(60);
    wr(REG_SWITCH_MODE, 16'h0000);
    $display("test_cmd_mode done");
  endtask

  task automatic test_ramp();
    logic [DATA_W-1:0] d;
    wr(REG_VALID_TIME, 16'h0032);
    wr(REG_SWITCH_TIME, 16'h0001);
    set_lvl(1'b1, 1'b1, 1'b0);
    wait_cyc(5);
    set_lvl(1'b1, 1'b0, 1'b0);
    wait_cyc(6);
    chk({77'h0, gain_state}, {77'h0, GS_THIRD});
    chk({79'h0, gain_out.pos_gain != 16'h00C8}, 80'h1);
    chk({64'h0, gain_out.speed_gain}, {64'h0, 16'h0064});
    rd(REG_REMAIN, d);
    chk({79'h0, d >= 16'h0030 && d <= 16'h0032}, 80'h1);
    wait_cyc(400);
    chk({64'h0, gain_out.pos_gain}, {64'h0, 16'h00C8});
    wait_cyc(200);
    chk({77'h0, gain_state}, {77'h0, GS_FIRST});
    $display("test_ramp done");
  endtask

  initial begin
    resetn = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    servo_on = 1'b0;
    cond2 = 1'b0;
    pos_cmd = 1'b0;
    dist_est = 16'sd100;
    torque_in = 16'sd1000;
    fail_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    test_regs();
    test_observer();
    test_filter();
    test_third();
    test_cmd_mode();
    test_ramp();
    tally_and_finish();
  end
endmodule // test_servo_gain_observer_select
`default_nettype wire
